// File: shared/eee_map.svh
// Offsets, field positions, reset values and portal encodings of the EEE MMD bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EEE_MAP_SVH
`define EEE_MAP_SVH

// ****************************************
// Portal registers
// ****************************************
`define EEE_PORTAL_CTRL_ADDR 5'h0d
`define EEE_PORTAL_DATA_ADDR 5'h0e
`define EEE_OP_MSB 15
`define EEE_OP_LSB 14
`define EEE_DEV_MSB 4

// ****************************************
// MMD devices and registers
// ****************************************
`define EEE_DEV_PMA 5'h01
`define EEE_DEV_AN 5'h07
`define EEE_DEV_DSP 5'h1c
`define EEE_REG_PMA_CTRL 16'h0000
`define EEE_REG_PMA_STAT 16'h0001
`define EEE_REG_LOCAL_ADV 16'h003c
`define EEE_REG_PARTNER_ADV 16'h003d
`define EEE_REG_DRIVE_CTRL 16'h0004

// ****************************************
// Field positions and resets
// ****************************************
`define EEE_LPI_EN_BIT 12
`define EEE_LPI_ENTERED_BIT 8
`define EEE_LPI_NOW_BIT 3
`define EEE_GIG_BIT 2
`define EEE_FAST_BIT 1
`define EEE_DRIVE_SEL_BIT 13
`define EEE_DRIVE_RW15_BIT 15
`define EEE_DRIVE_RW12_BIT 12
`define EEE_PMA_CTRL_RST 16'h0000
`define EEE_DRIVE_CTRL_RST 16'h2000

`endif

// File: shared/eee_pkg.sv
// Types shared by the EEE MMD bank modules.
// Assumes the map header sits on the include path.
package eee_pkg;
	`include "eee_map.svh"

	typedef enum logic [1:0] {
		EEE_OP_ADDR,
		EEE_OP_DATA,
		EEE_OP_INC_RW,
		EEE_OP_INC_WR
	} eee_op_type;

	typedef struct packed {
		logic prev;
		logic rise;
	} eee_edge_type;

	typedef struct packed {
		logic [15:0] portal_ctrl;
		logic [15:0] mmd_addr;
		logic [15:0] pma_ctrl;
		logic lpi_entered;
		logic local_fast;
		logic [15:0] drive_ctrl;
		logic [15:0] rdata;
		logic lpi_now;
		logic partner_gig;
		logic partner_fast;
		logic lpi_enable;
		logic drive_full;
	} eee_state_type;
endpackage

// File: logic/eee_edge.sv
// Rising-edge detector for the LPI-state level.
// Assumes the level is already synchronous to clock.
`timescale 1ns/10ps
module eee_edge
	import eee_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic level,
	output logic rise
);
	eee_edge_type st_reg;
	eee_edge_type st_next;

	always_comb begin
		st_next.prev = level;
		st_next.rise = level & ~st_reg.prev;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Registered so the latch sees the entry one cycle after the level rises
	assign rise = st_reg.rise;
endmodule

// File: logic/eee_mmd_register_bank.sv
// EEE MMD register bank reached through the two management portal registers.
// Assumes a management front end that decodes MDIO frames into one-cycle strobes.
`timescale 1ns/10ps
`include "eee_map.svh"
module eee_mmd_register_bank
	import eee_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic lpi_active,
	input wire logic partner_gig_adv,
	input wire logic partner_fast_adv,
	output logic [15:0] mgmt_rdata,
	output logic lpi_state,
	output logic lpi_enable,
	output logic local_fast_adv,
	output logic drive_full_amp,
	output logic partner_gig,
	output logic partner_fast
);
	eee_state_type st_reg;
	eee_state_type st_next;
	logic lpi_rise;

	eee_edge i_eee_edge (
		.clock(clock),
		.rstn(rstn),
		.level(lpi_active),
		.rise(lpi_rise)
	);

	// ****************************************
	// Indirect access decode
	// ****************************************
	eee_op_type op;
	logic [4:0] dev;
	logic data_wr;
	logic data_rd;
	logic stat_hit;
	logic [15:0] mmd_val;

	always_comb begin
		op = eee_op_type'(st_reg.portal_ctrl[`EEE_OP_MSB:`EEE_OP_LSB]);
		dev = st_reg.portal_ctrl[`EEE_DEV_MSB:0];
		data_wr = mgmt_wr && mgmt_addr == `EEE_PORTAL_DATA_ADDR && op != EEE_OP_ADDR;
		data_rd = mgmt_rd && mgmt_addr == `EEE_PORTAL_DATA_ADDR && op != EEE_OP_ADDR;
		stat_hit = dev == `EEE_DEV_PMA && st_reg.mmd_addr == `EEE_REG_PMA_STAT;
		mmd_val = 16'h0000;
		if (dev == `EEE_DEV_PMA && st_reg.mmd_addr == `EEE_REG_PMA_CTRL) begin
			mmd_val = st_reg.pma_ctrl;
		end else if (stat_hit) begin
			mmd_val[`EEE_LPI_ENTERED_BIT] = st_reg.lpi_entered;
			mmd_val[`EEE_LPI_NOW_BIT] = st_reg.lpi_now;
		end else if (dev == `EEE_DEV_AN && st_reg.mmd_addr == `EEE_REG_LOCAL_ADV) begin
			mmd_val[`EEE_FAST_BIT] = st_reg.local_fast;
			mmd_val[`EEE_GIG_BIT] = 1'b0;
		end else if (dev == `EEE_DEV_AN && st_reg.mmd_addr == `EEE_REG_PARTNER_ADV) begin
			mmd_val[`EEE_GIG_BIT] = st_reg.partner_gig;
			mmd_val[`EEE_FAST_BIT] = st_reg.partner_fast;
		end else if (dev == `EEE_DEV_DSP && st_reg.mmd_addr == `EEE_REG_DRIVE_CTRL) begin
			mmd_val = st_reg.drive_ctrl;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.lpi_now = lpi_active;
		st_next.partner_gig = partner_gig_adv;
		st_next.partner_fast = partner_fast_adv;
		if (mgmt_wr && mgmt_addr == `EEE_PORTAL_CTRL_ADDR) begin
			st_next.portal_ctrl = mgmt_wdata;
		end
		if (mgmt_wr && mgmt_addr == `EEE_PORTAL_DATA_ADDR && op == EEE_OP_ADDR) begin
			st_next.mmd_addr = mgmt_wdata;
		end
		if (data_wr) begin
			if (dev == `EEE_DEV_PMA && st_reg.mmd_addr == `EEE_REG_PMA_CTRL) begin
				st_next.pma_ctrl = mgmt_wdata;
			end else if (dev == `EEE_DEV_AN && st_reg.mmd_addr == `EEE_REG_LOCAL_ADV) begin
				st_next.local_fast = mgmt_wdata[`EEE_FAST_BIT];
			end else if (dev == `EEE_DEV_DSP && st_reg.mmd_addr == `EEE_REG_DRIVE_CTRL) begin
				// Only bits 15, 13 and 12 are plain storage; bit 14 and bits 11:0 keep their reset zero
				st_next.drive_ctrl[`EEE_DRIVE_RW15_BIT] = mgmt_wdata[`EEE_DRIVE_RW15_BIT];
				st_next.drive_ctrl[`EEE_DRIVE_SEL_BIT] = mgmt_wdata[`EEE_DRIVE_SEL_BIT];
				st_next.drive_ctrl[`EEE_DRIVE_RW12_BIT] = mgmt_wdata[`EEE_DRIVE_RW12_BIT];
			end
		end
		// Post increment after the access completes
		if ((data_wr && op != EEE_OP_DATA) || (data_rd && op == EEE_OP_INC_RW)) begin
			st_next.mmd_addr = st_reg.mmd_addr + 16'h0001;
		end
		// Set wins over the read clear so an entry in the read cycle is kept
		if (data_rd && stat_hit) begin
			st_next.lpi_entered = 1'b0;
		end
		if (lpi_rise) begin
			st_next.lpi_entered = 1'b1;
		end
		if (mgmt_rd) begin
			if (mgmt_addr == `EEE_PORTAL_CTRL_ADDR) begin
				st_next.rdata = st_reg.portal_ctrl;
			end else if (mgmt_addr == `EEE_PORTAL_DATA_ADDR) begin
				st_next.rdata = (op == EEE_OP_ADDR) ? st_reg.mmd_addr : mmd_val;
			end else begin
				st_next.rdata = 16'h0000;
			end
		end
		st_next.lpi_enable = st_next.pma_ctrl[`EEE_LPI_EN_BIT];
		st_next.drive_full = st_next.drive_ctrl[`EEE_DRIVE_SEL_BIT];
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.pma_ctrl <= `EEE_PMA_CTRL_RST;
			st_reg.drive_ctrl <= `EEE_DRIVE_CTRL_RST;
			st_reg.drive_full <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mgmt_rdata = st_reg.rdata;
	assign lpi_state = st_reg.lpi_now;
	assign lpi_enable = st_reg.lpi_enable;
	assign local_fast_adv = st_reg.local_fast;
	assign drive_full_amp = st_reg.drive_full;
	assign partner_gig = st_reg.partner_gig;
	assign partner_fast = st_reg.partner_fast;
endmodule

// File: bench/eee_bank_monitor.sv
// Port checker of the EEE register bank.
// Assumes binding to every bank instance.
`timescale 1ns/10ps
module eee_bank_monitor(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic lpi_active,
	input wire logic partner_gig_adv,
	input wire logic partner_fast_adv,
	input wire logic [15:0] mgmt_rdata,
	input wire logic lpi_state,
	input wire logic lpi_enable,
	input wire logic local_fast_adv,
	input wire logic drive_full_amp,
	input wire logic partner_gig,
	input wire logic partner_fast
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	lpi_live_a: assert property ($changed(lpi_active) |=> lpi_state == $past(lpi_active))
		else $error("lpi lag");
	gig_follow_a: assert property ($changed(partner_gig_adv) |=> partner_gig == $past(partner_gig_adv))
		else $error("gig lag");
	fast_follow_a: assert property ($changed(partner_fast_adv) |=> partner_fast == $past(partner_fast_adv))
		else $error("fast lag");
	enable_hold_a: assert property (!mgmt_wr |=> $stable(lpi_enable)) else $error("enable moved");
	adv_hold_a: assert property (!mgmt_wr |=> $stable(local_fast_adv)) else $error("adv moved");
	drive_hold_a: assert property (!mgmt_wr |=> $stable(drive_full_amp)) else $error("drive moved");
	rdata_hold_a: assert property (!mgmt_rd [*2] |=> $stable(mgmt_rdata)) else $error("rdata moved");
	unmapped_read_a: assert property (mgmt_rd && mgmt_addr == 5'h13 |-> ##[1:2] mgmt_rdata == 16'h0000)
		else $error("unmapped data");
endmodule
bind eee_mmd_register_bank eee_bank_monitor i_eee_bank_monitor(.*);

// File: bench/eee_host.sv
// Management host model driving the two portal registers.
// Assumes its tasks are called from one process only.
`timescale 1ns/10ps
module eee_host(
	input wire logic clock,
	input wire logic [15:0] mgmt_rdata,
	output logic [4:0] mgmt_addr,
	output logic [15:0] mgmt_wdata,
	output logic mgmt_wr,
	output logic mgmt_rd
);
	initial begin
		mgmt_addr = 5'h00;
		mgmt_wdata = 16'h0000;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		mgmt_addr <= a;
		mgmt_wdata <= d;
		mgmt_wr <= 1'b1;
		@(posedge clock);
		mgmt_wr <= 1'b0;
		// Stale data never looks valid
		mgmt_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		mgmt_addr <= a;
		mgmt_rd <= 1'b1;
		@(posedge clock);
		mgmt_rd <= 1'b0;
		@(posedge clock);
		#1 d = mgmt_rdata;
	endtask
	task automatic mmd(input logic [4:0] dev, input logic [15:0] r, input logic [1:0] op);
		wr(5'h0d, {11'h000, dev});
		wr(5'h0e, r);
		wr(5'h0d, {op, 9'h000, dev});
	endtask
endmodule

// File: bench/tb_eee_mmd_register_bank.sv
// Self-checking bench of the EEE register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb_eee_mmd_register_bank;
	logic clock, rstn, lpi_active, partner_gig_adv, partner_fast_adv, mgmt_wr, mgmt_rd;
	logic lpi_state, lpi_enable, local_fast_adv, drive_full_amp, partner_gig, partner_fast;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, v, r;
	int errors = 0;
	int total_checks = 0;
	eee_host i_eee_host(.*);
	eee_mmd_register_bank i_eee_mmd_register_bank(.*);
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rmmd(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] exp);
		i_eee_host.mmd(dev, a, 2'b01);
		i_eee_host.rd(5'h0e, r);
		chk(r, exp);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		give_verdict;
	end
	initial begin
		v = 16'h000a;
		{rstn, lpi_active, partner_gig_adv, partner_fast_adv} = 4'h0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1 chk({10'h000, lpi_state, lpi_enable, local_fast_adv, drive_full_amp, partner_gig, partner_fast}, 16'h0004);
		rmmd(5'h01, 16'h0000, 16'h0000);
		rmmd(5'h07, 16'h003c, 16'h0000);
		rmmd(5'h07, 16'h003d, 16'h0000);
		rmmd(5'h1c, 16'h0004, 16'h2000);
		$display("reset test done");
		repeat (3) begin
			v = lfsr(v);
			i_eee_host.mmd(5'h01, 16'h0000, 2'b01);
			i_eee_host.wr(5'h0e, v);
			i_eee_host.rd(5'h0e, r);
			chk(r, v);
			chk({15'h0000, lpi_enable}, {15'h0000, v[12]});
			i_eee_host.mmd(5'h1c, 16'h0004, 2'b01);
			i_eee_host.wr(5'h0e, v);
			i_eee_host.wr(5'h13, {11'h000, ~v[13], 4'h0});
			i_eee_host.rd(5'h0e, r);
			chk(r, v & 16'hb000);
			chk({15'h0000, drive_full_amp}, {15'h0000, v[13]});
			i_eee_host.rd(5'h13, r);
			chk(r, 16'h0000);
		end
		$display("random test done");
		@(posedge clock);
		{partner_gig_adv, partner_fast_adv} <= 2'b11;
		i_eee_host.mmd(5'h07, 16'h003c, 2'b11);
		i_eee_host.wr(5'h0e, 16'hffff);
		i_eee_host.rd(5'h0e, r);
		chk(r, 16'h0006);
		i_eee_host.rd(5'h0e, r);
		chk(r, 16'h0006);
		i_eee_host.mmd(5'h07, 16'h003c, 2'b10);
		i_eee_host.rd(5'h0e, r);
		chk(r, 16'h0002);
		i_eee_host.rd(5'h0e, r);
		chk(r, 16'h0006);
		chk({13'h0000, local_fast_adv, partner_gig, partner_fast}, 16'h0007);
		$display("adv test done");
		@(posedge clock);
		lpi_active <= 1'b1;
		rmmd(5'h01, 16'h0001, 16'h0108);
		chk({15'h0000, lpi_state}, 16'h0001);
		rmmd(5'h01, 16'h0001, 16'h0008);
		@(posedge clock);
		lpi_active <= 1'b0;
		rmmd(5'h01, 16'h0001, 16'h0000);
		chk({15'h0000, lpi_state}, 16'h0000);
		@(posedge clock);
		lpi_active <= 1'b1;
		@(posedge clock);
		lpi_active <= 1'b0;
		rmmd(5'h01, 16'h0001, 16'h0100);
		i_eee_host.mmd(5'h01, 16'h0001, 2'b00);
		i_eee_host.rd(5'h0e, r);
		chk(r, 16'h0001);
		$display("lpi test done");
		give_verdict;
	end
endmodule
